// ==== verilog/umh_top.sv ====
// Modem control and status handshake for two serial ports, with a byte register port.
// Assumes a single 10 MHz clock, synchronous active-low reset, and a bus master
// that issues one-cycle read or write strobes and never needs a wait state.
`timescale 1ns/1ns

module umh_top
(
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic [`UMH_ADDR_W-1:0] reg_addr_in,
  input wire logic [`UMH_DATA_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic carrier_detect_in_n,
  input wire logic set_ready_in_n,
  input wire logic clear_to_send_in_n,
  input wire logic ring_indicate_in_n,
  input wire logic port2_ring_indicate_in_n,
  input wire logic tx_data_in,
  output logic [`UMH_DATA_W-1:0] reg_rdata_out,
  output logic port1_serial_out,
  output logic request_to_send_out_n,
  output logic terminal_ready_out_n,
  output logic port1_irq_out,
  output logic port2_irq_out,
  output logic irq_out
);

  localparam int NP = `UMH_NUM_PINS;

  function automatic logic [3:0] sticky4(input logic [3:0] cur, input logic [3:0] set, input logic clr);
    // Set wins over a clear in the same cycle
    sticky4 = (cur & {4{~clr}}) | set;
  endfunction

  function automatic logic [NP-1:0] agree(input logic [NP-1:0] s2, input logic [NP-1:0] s3,
                                          input logic [NP-1:0] held);
    agree = (~(s2 ^ s3) & s3) | ((s2 ^ s3) & held);
  endfunction

  // Pin conditioning: three stages, level accepted once stages two and three agree
  logic [NP-1:0] pins_raw;
  logic [NP-1:0] sync1_q;
  logic [NP-1:0] sync2_q;
  logic [NP-1:0] sync3_q;
  logic [NP-1:0] lvl_q;
  logic [NP-1:0] lvl_d;
  logic [NP-1:0] pin_rise;
  logic [NP-1:0] pin_change;

  assign pins_raw[`UMH_PIN_DCD] = carrier_detect_in_n;
  assign pins_raw[`UMH_PIN_DSR] = set_ready_in_n;
  assign pins_raw[`UMH_PIN_CTS] = clear_to_send_in_n;
  assign pins_raw[`UMH_PIN_RI] = ring_indicate_in_n;
  assign pins_raw[`UMH_PIN_RI2] = port2_ring_indicate_in_n;

  assign lvl_d = agree(sync2_q, sync3_q, lvl_q);
  assign pin_rise = lvl_d & ~lvl_q;
  assign pin_change = lvl_d ^ lvl_q;

  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      sync1_q <= `UMH_RST_PINS;
      sync2_q <= `UMH_RST_PINS;
      sync3_q <= `UMH_RST_PINS;
      lvl_q <= `UMH_RST_PINS;
    end
    else
    begin
      sync1_q <= pins_raw;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      lvl_q <= lvl_d;
    end
  end

  // Asserted levels, as software sees them
  umh_pkg::umh_modem_s mdm1;
  logic ri2_on;

  assign mdm1.dcd = ~lvl_q[`UMH_PIN_DCD];
  assign mdm1.dsr = ~lvl_q[`UMH_PIN_DSR];
  assign mdm1.cts = ~lvl_q[`UMH_PIN_CTS];
  assign mdm1.ri = ~lvl_q[`UMH_PIN_RI];
  assign ri2_on = ~lvl_q[`UMH_PIN_RI2];

  // Register decode
  wire sel_en1 = (reg_addr_in == `UMH_OFF_INT_EN1);
  wire sel_mcr1 = (reg_addr_in == `UMH_OFF_MCR1);
  wire sel_msr1 = (reg_addr_in == `UMH_OFF_MSR1);
  wire sel_en2 = (reg_addr_in == `UMH_OFF_INT_EN2);
  wire sel_msr2 = (reg_addr_in == `UMH_OFF_MSR2);
  wire sel_stat = (reg_addr_in == `UMH_OFF_EVT_STAT);
  wire sel_mask = (reg_addr_in == `UMH_OFF_EVT_MASK);

  wire wr_en1 = reg_wr_in & sel_en1;
  wire wr_mcr1 = reg_wr_in & sel_mcr1;
  wire wr_en2 = reg_wr_in & sel_en2;
  wire wr_stat = reg_wr_in & sel_stat;
  wire wr_mask = reg_wr_in & sel_mask;
  wire rd_msr1 = reg_rd_in & sel_msr1;
  wire rd_msr2 = reg_rd_in & sel_msr2;

  // Software control registers
  umh_pkg::umh_byte_t int_en1_q;
  umh_pkg::umh_byte_t int_en2_q;
  umh_pkg::umh_byte_t mcr1_q;
  logic [NP-1:0] evt_mask_q;

  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      int_en1_q <= `UMH_RST_REG8;
      int_en2_q <= `UMH_RST_REG8;
      mcr1_q <= `UMH_RST_REG8;
      evt_mask_q <= `UMH_RST_EVT;
    end
    else
    begin
      if (wr_en1)
      begin
        int_en1_q <= reg_wdata_in;
      end
      if (wr_en2)
      begin
        int_en2_q <= reg_wdata_in;
      end
      if (wr_mcr1)
      begin
        mcr1_q <= reg_wdata_in;
      end
      if (wr_mask)
      begin
        evt_mask_q <= reg_wdata_in[NP-1:0];
      end
    end
  end

  // Change-detect flags, cleared by reading the owning status register
  umh_pkg::umh_delta_s delta1_q;
  umh_pkg::umh_delta_s delta1_d;
  umh_pkg::umh_delta_s delta1_set;
  logic [3:0] delta2_q;
  logic [3:0] delta2_d;
  logic [3:0] delta2_set;

  assign delta1_set.ddcd = pin_rise[`UMH_PIN_DCD];
  assign delta1_set.ddsr = pin_rise[`UMH_PIN_DSR];
  assign delta1_set.dcts = pin_rise[`UMH_PIN_CTS];
  assign delta1_set.dri = pin_rise[`UMH_PIN_RI];
  assign delta2_set = {1'b0, pin_rise[`UMH_PIN_RI2], 2'b00};

  assign delta1_d = sticky4(delta1_q, delta1_set, rd_msr1);
  assign delta2_d = sticky4(delta2_q, delta2_set, rd_msr2);

  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      delta1_q <= `UMH_RST_DELTA4;
      delta2_q <= `UMH_RST_DELTA4;
    end
    else
    begin
      delta1_q <= delta1_d;
      delta2_q <= delta2_d;
    end
  end

  // Sticky change events, any direction, write one to clear
  logic [NP-1:0] evt_stat_q;
  logic [NP-1:0] evt_stat_d;
  logic [NP-1:0] evt_clr;

  assign evt_clr = wr_stat ? reg_wdata_in[NP-1:0] : `UMH_RST_EVT;
  assign evt_stat_d = (evt_stat_q & ~evt_clr) | pin_change;

  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      evt_stat_q <= `UMH_RST_EVT;
    end
    else
    begin
      evt_stat_q <= evt_stat_d;
    end
  end

  // Status register images
  umh_pkg::umh_byte_t msr1_img;
  umh_pkg::umh_byte_t msr2_img;

  assign msr1_img[`UMH_MSTAT_DCD_BIT] = mdm1.dcd;
  assign msr1_img[`UMH_MSTAT_RI_BIT] = mdm1.ri;
  assign msr1_img[`UMH_MSTAT_DSR_BIT] = mdm1.dsr;
  assign msr1_img[`UMH_MSTAT_CTS_BIT] = mdm1.cts;
  assign msr1_img[`UMH_MSTAT_DDCD_BIT] = delta1_q.ddcd;
  assign msr1_img[`UMH_MSTAT_DRI_BIT] = delta1_q.dri;
  assign msr1_img[`UMH_MSTAT_DDSR_BIT] = delta1_q.ddsr;
  assign msr1_img[`UMH_MSTAT_DCTS_BIT] = delta1_q.dcts;

  // Port two has only the ring input in this block
  assign msr2_img = {1'b0, ri2_on, 2'b00, delta2_q};

  // Read data, valid only in the cycle after the strobe
  umh_pkg::umh_byte_t rdata_d;
  umh_pkg::umh_byte_t rdata_q;

  always_comb
  begin
    rdata_d = `UMH_RST_REG8;
    if (reg_rd_in)
    begin
      unique case (1'b1)
        sel_en1: rdata_d = int_en1_q;
        sel_mcr1: rdata_d = mcr1_q;
        sel_msr1: rdata_d = msr1_img;
        sel_en2: rdata_d = int_en2_q;
        sel_msr2: rdata_d = msr2_img;
        sel_stat: rdata_d = {{(`UMH_DATA_W-NP){1'b0}}, evt_stat_q};
        sel_mask: rdata_d = {{(`UMH_DATA_W-NP){1'b0}}, evt_mask_q};
        default: rdata_d = `UMH_RST_REG8;
      endcase
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      rdata_q <= `UMH_RST_REG8;
    end
    else
    begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata_out = rdata_q;

  // Handshake outputs; loopback keeps the modem side idle
  wire loop_on = mcr1_q[`UMH_MCTL_LOOP_BIT];
  logic rts_n_d;
  logic dtr_n_d;
  logic rts_n_q;
  logic dtr_n_q;

  assign rts_n_d = loop_on | ~mcr1_q[`UMH_MCTL_RTS_BIT];
  assign dtr_n_d = loop_on | ~mcr1_q[`UMH_MCTL_DTR_BIT];

  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      rts_n_q <= 1'b1;
      dtr_n_q <= 1'b1;
    end
    else
    begin
      rts_n_q <= rts_n_d;
      dtr_n_q <= dtr_n_d;
    end
  end

  assign request_to_send_out_n = rts_n_q;
  assign terminal_ready_out_n = dtr_n_q;

  // Transmit path ignores clear to send; flow control is left to software
  logic txd_d;
  logic txd_q;

  assign txd_d = loop_on | tx_data_in;

  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      txd_q <= 1'b1;
    end
    else
    begin
      txd_q <= txd_d;
    end
  end

  assign port1_serial_out = txd_q;

  // Interrupts
  logic [NP-1:0] evt_stat_nxt_any;
  logic p1_irq_d;
  logic p2_irq_d;
  logic irq_d;
  logic p1_irq_q;
  logic p2_irq_q;
  logic irq_q;

  assign evt_stat_nxt_any = evt_stat_q;
  assign p1_irq_d = int_en1_q[`UMH_IER_MODEM_BIT] & (|evt_stat_nxt_any[`UMH_PIN_RI:`UMH_PIN_DCD]);
  assign p2_irq_d = int_en2_q[`UMH_IER_MODEM_BIT] & evt_stat_nxt_any[`UMH_PIN_RI2];
  assign irq_d = |(evt_stat_q & evt_mask_q);

  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      p1_irq_q <= 1'b0;
      p2_irq_q <= 1'b0;
      irq_q <= 1'b0;
    end
    else
    begin
      p1_irq_q <= p1_irq_d;
      p2_irq_q <= p2_irq_d;
      irq_q <= irq_d;
    end
  end

  assign port1_irq_out = p1_irq_q;
  assign port2_irq_out = p2_irq_q;
  assign irq_out = irq_q;

endmodule

// ==== verilog/umh_defines.svh ====
// Register offsets, field positions and reset values of the modem handshake block.
// Assumes inclusion by bare name from files under verilog/.
`ifndef UMH_DEFINES_SVH
`define UMH_DEFINES_SVH

`define UMH_ADDR_W 3
`define UMH_DATA_W 8

`define UMH_OFF_INT_EN1 3'h0
`define UMH_OFF_MCR1 3'h1
`define UMH_OFF_MSR1 3'h2
`define UMH_OFF_INT_EN2 3'h3
`define UMH_OFF_MSR2 3'h4
`define UMH_OFF_EVT_STAT 3'h5
`define UMH_OFF_EVT_MASK 3'h6

`define UMH_IER_MODEM_BIT 3
`define UMH_MCTL_DTR_BIT 0
`define UMH_MCTL_RTS_BIT 1
`define UMH_MCTL_LOOP_BIT 4

`define UMH_MSTAT_DCTS_BIT 0
`define UMH_MSTAT_DDSR_BIT 1
`define UMH_MSTAT_DRI_BIT 2
`define UMH_MSTAT_DDCD_BIT 3
`define UMH_MSTAT_CTS_BIT 4
`define UMH_MSTAT_DSR_BIT 5
`define UMH_MSTAT_RI_BIT 6
`define UMH_MSTAT_DCD_BIT 7

`define UMH_PIN_DCD 0
`define UMH_PIN_DSR 1
`define UMH_PIN_CTS 2
`define UMH_PIN_RI 3
`define UMH_PIN_RI2 4
`define UMH_NUM_PINS 5

`define UMH_RST_REG8 8'h00
`define UMH_RST_PINS 5'h1f
`define UMH_RST_DELTA4 4'h0
`define UMH_RST_EVT 5'h00

`endif

// ==== verilog/umh_pkg.sv ====
// Types shared by the modem handshake block.
// Assumes umh_defines.svh is reachable on the include path.
`include "umh_defines.svh"

package umh_pkg;

  // Conditioned modem levels, true when the pin is asserted (low)
  typedef struct packed {
    logic dcd;
    logic ri;
    logic dsr;
    logic cts;
  } umh_modem_s;

  // Change-detect flags of one port, in register bit order 3..0
  typedef struct packed {
    logic ddcd;
    logic dri;
    logic ddsr;
    logic dcts;
  } umh_delta_s;

  typedef logic [`UMH_DATA_W-1:0] umh_byte_t;

endpackage

// ==== tb/umh_top_chk.sv ====
// Concurrent checks on the modem handshake block, watching its ports only.
// Assumes a bind from the bench top and a single clock domain.
`timescale 1ns/1ns
`include "umh_defines.svh"
module umh_top_chk
(
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic [`UMH_ADDR_W-1:0] reg_addr_in,
  input wire logic [`UMH_DATA_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic carrier_detect_in_n,
  input wire logic set_ready_in_n,
  input wire logic clear_to_send_in_n,
  input wire logic ring_indicate_in_n,
  input wire logic port2_ring_indicate_in_n,
  input wire logic tx_data_in,
  input wire logic [`UMH_DATA_W-1:0] reg_rdata_out,
  input wire logic port1_serial_out,
  input wire logic request_to_send_out_n,
  input wire logic terminal_ready_out_n,
  input wire logic port1_irq_out,
  input wire logic port2_irq_out
);
  wire [3:0] lv = {carrier_detect_in_n, ring_indicate_in_n, set_ready_in_n, clear_to_send_in_n};
  wire [4:0] pins = {port2_ring_indicate_in_n, lv};
  wire rd1 = reg_rd_in && reg_addr_in == `UMH_OFF_MSR1;
  wire rd2 = reg_rd_in && reg_addr_in == `UMH_OFF_MSR2;
  wire mcr_wr = reg_wr_in && reg_addr_in == `UMH_OFF_MCR1;
  logic [4:0] pins_q;
  logic [3:0] cnt_q;
  logic loop_q;
  logic ien1_q;
  logic ien2_q;
  // Quiet-pin count: level checks wait until the synchroniser has settled
  always_ff @(posedge clock_in)
  begin
    pins_q <= pins;
    if (!rst_n_in || pins != pins_q)
      cnt_q <= 4'h0;
    else if (cnt_q != 4'hf)
      cnt_q <= cnt_q + 4'h1;
  end
  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
      {loop_q, ien1_q, ien2_q} <= 3'h0;
    else
    begin
      if (mcr_wr)
        loop_q <= reg_wdata_in[4];
      if (reg_wr_in && reg_addr_in == `UMH_OFF_INT_EN1)
        ien1_q <= reg_wdata_in[3];
      if (reg_wr_in && reg_addr_in == `UMH_OFF_INT_EN2)
        ien2_q <= reg_wdata_in[3];
    end
  end
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_quiet_rd1;
    rd1 && cnt_q > 4'h6 && pins == pins_q;
  endsequence
  AST_RTS: assert property (mcr_wr |-> ##2 request_to_send_out_n ==
    !($past(reg_wdata_in[1], 2) && !$past(reg_wdata_in[4], 2))) else $error("rts level wrong");
  AST_DTR: assert property (mcr_wr |-> ##2 terminal_ready_out_n ==
    !($past(reg_wdata_in[0], 2) && !$past(reg_wdata_in[4], 2))) else $error("dtr level wrong");
  AST_RESET_OUTS: assert property (@(posedge clock_in) disable iff (1'b0)
    !rst_n_in |=> request_to_send_out_n && terminal_ready_out_n) else $error("outputs active in reset");
  AST_TX_FREE: assert property (!loop_q |=> port1_serial_out == $past(tx_data_in))
    else $error("serial out gated");
  AST_IRQ1_EN: assert property (port1_irq_out |-> $past(ien1_q)) else $error("irq1 while disabled");
  AST_IRQ2_EN: assert property (port2_irq_out |-> $past(ien2_q)) else $error("irq2 while disabled");
  AST_MSR1_LVL: assert property (s_quiet_rd1 |=> reg_rdata_out[7:4] == ~$past(lv))
    else $error("status levels wrong");
  AST_MSR1_CLR: assert property (s_quiet_rd1 ##2 rd1 |=> reg_rdata_out[3:0] == 4'h0)
    else $error("deltas not cleared");
  // Pins must also hold at the read edge itself, or the synchroniser still shows the old level
  AST_MSR2_LVL: assert property (rd2 && cnt_q > 4'h6 && pins == pins_q |=> reg_rdata_out[6] ==
    !$past(port2_ring_indicate_in_n)) else $error("port two ring level wrong");
  AST_RD_IDLE: assert property (!reg_rd_in |=> reg_rdata_out == 8'h00) else $error("read data outside slot");
  COV_QUIET_RD: cover property (s_quiet_rd1);
  COV_IRQ1: cover property ($rose(port1_irq_out));
  COV_IRQ2: cover property ($rose(port2_irq_out));
  COV_RTS_ON: cover property ($fell(request_to_send_out_n));
endmodule

// ==== tb/umh_modem.sv ====
// Modem model: drives the five active-low status pins, idle high.
// Assumes the bench calls set just after a rising clock edge.
`timescale 1ns/1ns
module umh_modem
(
  output var logic [4:0] pins_n_out
);
  // Bit order follows the pin indices of the defines header
  initial pins_n_out = 5'h1f;
  task automatic set(input logic [4:0] v);
    pins_n_out <= v;
  endtask
endmodule

// ==== tb/umh_top_bench.sv ====
// Self-checking bench for the modem handshake block with a modem model.
// Assumes the design files, the modem model and the checker are compiled first.
`timescale 1ns/1ns
`include "umh_defines.svh"
module umh_top_bench;
  logic clock_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [`UMH_ADDR_W-1:0] reg_addr_in = 3'h0;
  logic [`UMH_DATA_W-1:0] reg_wdata_in = 8'h00;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic tx_data_in = 1'b1;
  wire [4:0] pins_n;
  logic [7:0] reg_rdata_out;
  logic port1_serial_out, request_to_send_out_n, terminal_ready_out_n;
  logic port1_irq_out, port2_irq_out, irq_out;
  int num_errors = 0;
  int checks_done = 0;
  int lb[4] = '{7, 5, 4, 6};
  umh_modem i_umh_modem (.pins_n_out(pins_n));
  umh_top i_umh_top (.clock_in(clock_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .carrier_detect_in_n(pins_n[0]), .set_ready_in_n(pins_n[1]), .clear_to_send_in_n(pins_n[2]),
    .ring_indicate_in_n(pins_n[3]), .port2_ring_indicate_in_n(pins_n[4]), .tx_data_in(tx_data_in),
    .reg_rdata_out(reg_rdata_out), .port1_serial_out(port1_serial_out),
    .request_to_send_out_n(request_to_send_out_n), .terminal_ready_out_n(terminal_ready_out_n),
    .port1_irq_out(port1_irq_out), .port2_irq_out(port2_irq_out), .irq_out(irq_out));
  initial forever #50 clock_in = ~clock_in;
  task automatic close_out();
    if (num_errors == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("BAD %s exp %h seen %h", name, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge clock_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rchk(input string name, input logic [2:0] a, input logic [7:0] exp);
    @(posedge clock_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge clock_in);
    reg_rd_in <= 1'b0;
    #1 chk(name, reg_rdata_out, exp);
  endtask
  // Synchroniser needs four edges; eight leaves the checker's quiet window open
  task automatic pin(input logic [4:0] v);
    @(posedge clock_in);
    i_umh_modem.set(v);
    cyc(8);
  endtask
  function automatic logic [7:0] irqs();
    return {5'h00, port2_irq_out, port1_irq_out, irq_out};
  endfunction
  task automatic t_reset();
    chk("rts dtr", {6'h00, request_to_send_out_n, terminal_ready_out_n}, 8'h03);
    rchk("msr1 idle", `UMH_OFF_MSR1, 8'h00);
    rchk("unmapped", 3'h7, 8'h00);
  endtask
  task automatic t_control();
    for (int v = 0; v < 4; v++)
    begin
      wr(`UMH_OFF_MCR1, 8'(v));
      cyc(2);
      chk("rts dtr", {6'h00, request_to_send_out_n, terminal_ready_out_n}, {6'h00, ~2'(v)});
    end
    wr(`UMH_OFF_MCR1, 8'h13);
    cyc(2);
    chk("loop rts dtr", {6'h00, request_to_send_out_n, terminal_ready_out_n}, 8'h03);
    wr(`UMH_OFF_MCR1, 8'h00);
  endtask
  task automatic t_midreset();
    wr(`UMH_OFF_MCR1, 8'h03);
    cyc(2);
    chk("rts dtr on", {6'h00, request_to_send_out_n, terminal_ready_out_n}, 8'h00);
    rchk("ctl back", `UMH_OFF_MCR1, 8'h03);
    @(posedge clock_in);
    rst_n_in <= 1'b0;
    repeat (2) @(posedge clock_in);
    rst_n_in <= 1'b1;
    cyc(1);
    chk("reset rts dtr", {6'h00, request_to_send_out_n, terminal_ready_out_n}, 8'h03);
    rchk("ctl reset", `UMH_OFF_MCR1, 8'h00);
  endtask
  task automatic t_levels();
    for (int i = 0; i < 4; i++)
    begin
      pin(5'h1f & ~(5'h01 << i));
      rchk("msr1 low", `UMH_OFF_MSR1, 8'h01 << lb[i]);
      pin(5'h1f);
      rchk("msr1 rise", `UMH_OFF_MSR1, 8'h01 << (lb[i] - 4));
      rchk("msr1 again", `UMH_OFF_MSR1, 8'h00);
    end
  endtask
  task automatic t_irq();
    wr(`UMH_OFF_INT_EN1, 8'h08);
    wr(`UMH_OFF_EVT_MASK, 8'h1f);
    wr(`UMH_OFF_EVT_STAT, 8'h1f);
    cyc(2);
    chk("irq idle", irqs(), 8'h00);
    pin(5'h1b);
    chk("irq cts", irqs(), 8'h03);
    rchk("evt cts", `UMH_OFF_EVT_STAT, 8'h04);
    // Transmit path must follow tx data while clear to send is held low
    for (int k = 0; k < 4; k++)
    begin
      @(posedge clock_in);
      tx_data_in <= k[0];
      cyc(1);
      chk("serial out", {7'h00, port1_serial_out}, {7'h00, k[0]});
    end
    wr(`UMH_OFF_EVT_MASK, 8'h00);
    wr(`UMH_OFF_EVT_STAT, 8'h1f);
    wr(`UMH_OFF_INT_EN1, 8'h00);
    pin(5'h1f);
    chk("irq masked", irqs(), 8'h00);
    wr(`UMH_OFF_INT_EN2, 8'h08);
    pin(5'h0f);
    chk("irq ring2", irqs(), 8'h04);
    rchk("msr2 low", `UMH_OFF_MSR2, 8'h40);
    pin(5'h1f);
    rchk("msr2 rise", `UMH_OFF_MSR2, 8'h04);
    wr(`UMH_OFF_EVT_STAT, 8'h1f);
    cyc(2);
    chk("irq cleared", irqs(), 8'h00);
  endtask
  initial
  begin
    repeat (2) @(posedge clock_in);
    rst_n_in <= 1'b1;
    cyc(1);
    t_reset();
    t_control();
    t_midreset();
    t_levels();
    t_irq();
    close_out();
  end
  initial
  begin
    #2000000;
    num_errors++;
    close_out();
  end
endmodule
bind umh_top umh_top_chk i_umh_top_chk (.*);
